// File: dsm_regs.sv
// Purpose: read-only monitor register bank of a lift motor drive
// Assumes: link framing decoded elsewhere; one read request per strobe
// Assumes: monitor words arrive already scaled
// Notes: answer registered one cycle after the request
//
// Contract
// [R1] status bits 0-3, 6 from drive conditions
// [R2] bit 4 set when frequency at/below level
// [R3] bit 5 set when frequency at/above level
// [R4] bits 7,8,B,C,D report condition flags
// [R5] bits 9,A: 0 when source is comms
// [R6] bit F timeout; bit E any error
// [R7] relay contacts in bits 0-2, rest zero
// [R8] link error bits held until error reset
// [R9] unknown register answers exception 02h
// [R10] unused bits and registers read zero
`timescale 1ns/1ps
module dsm_regs
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_en,

  // drive conditions
  input  wire logic        drive_running,
  input  wire logic        zero_speed,
  input  wire logic        freq_agree,
  input  wire logic        user_speed_agree,
  input  wire logic [15:0] output_freq,
  input  wire logic [15:0] freq_detect_level,
  input  wire logic        startup_done,
  input  wire logic        undervoltage,
  input  wire logic        gating_blocked,
  input  wire logic        fref_from_comms,
  input  wire logic        run_from_comms,
  input  wire logic        overtorque,
  input  wire logic        fref_lost,
  input  wire logic        restarting,
  input  wire logic        drive_error,
  input  wire logic        link_timeout,

  // relay contacts
  input  wire logic        relay_out1_pins,
  input  wire logic        relay_out2_pins,
  input  wire logic        relay_out3_pins,

  // monitor values
  input  wire logic [15:0] dc_bus_voltage,
  input  wire logic [15:0] torque_monitor_item,
  input  wire logic [15:0] power_monitor_item,
  input  wire logic [15:0] cpu_software_number,
  input  wire logic [15:0] flash_software_number,
  input  wire logic [15:0] drive_capacity_setting,
  input  wire logic [15:0] control_method_code,

  // receive fault events
  input  wire logic        rx_crc_error,
  input  wire logic        rx_length_error,
  input  wire logic        rx_parity_error,
  input  wire logic        rx_overrun_error,
  input  wire logic        rx_framing_error,
  input  wire logic        rx_timeout_error,
  input  wire logic        error_reset,

  // register read port
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic [7:0]       rd_exception
);

  logic [15:0] status_word;
  logic [15:0] relay_word;
  logic [6:0]  err_q;
  logic [6:0]  err_d;
  logic [6:0]  err_events;
  logic [15:0] read_word;
  logic        read_hit;
  logic [1:0]  freq_flags;

  // frequency detection flags, both set on equality
  function automatic logic [1:0] dsm_freq_flags(input logic [15:0] freq,
                                                input logic [15:0] level);
    logic at_below;
    logic at_above;
    at_below = freq <= level; // see [R2]
    at_above = freq >= level; // see [R3]
    return {at_above, at_below};
  endfunction

  // register numbers present in this bank
  function automatic logic dsm_known_reg(input logic [15:0] addr);
    logic known;
    unique case (addr)
      dsm_pkg::ADDR_DRIVE_STATUS,
      dsm_pkg::ADDR_RELAY_STATUS,
      dsm_pkg::ADDR_DC_BUS_VOLTAGE,
      dsm_pkg::ADDR_TORQUE_READOUT,
      dsm_pkg::ADDR_POWER_READOUT,
      dsm_pkg::ADDR_CPU_SW_NUMBER,
      dsm_pkg::ADDR_FLASH_SW_NUMBER,
      dsm_pkg::ADDR_LINK_ERROR,
      dsm_pkg::ADDR_CAPACITY,
      dsm_pkg::ADDR_CONTROL_METHOD:
      begin
        known = 1'b1;
      end
      default:
      begin
        known = 1'b0; // see [R9]
      end
    endcase
    return known;
  endfunction

  // exception code for a read of a present or absent register
  function automatic logic [7:0] dsm_exc_code(input logic known);
    logic [7:0] code;
    if (known)
    begin
      code = dsm_pkg::EXC_NONE;
    end
    else
    begin
      code = dsm_pkg::EXC_BAD_REGISTER; // see [R9]
    end
    return code;
  endfunction

  // next held fault bits; a new fault wins over a same-cycle reset
  function automatic logic [6:0] dsm_err_next(input logic [6:0] held,
                                              input logic [6:0] events,
                                              input logic       clear);
    logic [6:0] latched;
    if (clear)
    begin
      latched = events & dsm_pkg::ERR_USED_MASK; // see [R8]
    end
    else
    begin
      latched = (held | events) & dsm_pkg::ERR_USED_MASK; // see [R8]
    end
    return latched;
  endfunction

  assign freq_flags = dsm_freq_flags(output_freq, freq_detect_level);

  // status word from live drive conditions
  always_comb
  begin
    status_word = dsm_pkg::DATA_RESET_VAL;
    status_word[dsm_pkg::ST_RUNNING]      = drive_running;      // see [R1]
    status_word[dsm_pkg::ST_ZERO_SPEED]   = zero_speed;         // see [R1]
    status_word[dsm_pkg::ST_FREQ_AGREE]   = freq_agree;         // see [R1]
    status_word[dsm_pkg::ST_USER_AGREE]   = user_speed_agree;   // see [R1]
    status_word[dsm_pkg::ST_FREQ_AT_BELOW] = freq_flags[0];      // see [R2]
    status_word[dsm_pkg::ST_FREQ_AT_ABOVE] = freq_flags[1];      // see [R3]
    status_word[dsm_pkg::ST_STARTUP_DONE] = startup_done;       // see [R1]
    status_word[dsm_pkg::ST_UNDERVOLT]    = undervoltage;       // see [R4]
    status_word[dsm_pkg::ST_GATE_BLOCKED] = gating_blocked;     // see [R4]
    status_word[dsm_pkg::ST_FREF_NOT_COM] = !fref_from_comms;   // see [R5]
    status_word[dsm_pkg::ST_RUN_NOT_COM]  = !run_from_comms;    // see [R5]
    status_word[dsm_pkg::ST_OVERTORQUE]   = overtorque;         // see [R4]
    status_word[dsm_pkg::ST_FREF_LOST]    = fref_lost;          // see [R4]
    status_word[dsm_pkg::ST_RESTARTING]   = restarting;         // see [R4]
    status_word[dsm_pkg::ST_ANY_ERROR]    = drive_error || link_timeout; // see [R6]
    status_word[dsm_pkg::ST_LINK_TIMEOUT] = link_timeout;       // see [R6]
  end

  // relay contact word
  always_comb
  begin
    relay_word = dsm_pkg::DATA_RESET_VAL;
    relay_word[0] = relay_out1_pins; // see [R7]
    relay_word[1] = relay_out2_pins; // see [R7]
    relay_word[2] = relay_out3_pins; // see [R7]
  end

  // receive fault events onto their bit positions
  always_comb
  begin
    err_events = dsm_pkg::ERR_RESET_VAL;
    err_events[dsm_pkg::ERR_CRC]     = rx_crc_error;
    err_events[dsm_pkg::ERR_LENGTH]  = rx_length_error;
    err_events[dsm_pkg::ERR_PARITY]  = rx_parity_error;
    err_events[dsm_pkg::ERR_OVERRUN] = rx_overrun_error;
    err_events[dsm_pkg::ERR_FRAMING] = rx_framing_error;
    err_events[dsm_pkg::ERR_TIMEOUT] = rx_timeout_error;
  end

  // fault bits held until an error reset
  always_comb
  begin
    err_d = dsm_err_next(err_q, err_events, error_reset); // see [R8]
  end

  // error latch, frozen while the clock enable is low
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      err_q <= dsm_pkg::ERR_RESET_VAL;
    end
    else if (clock_en)
    begin
      err_q <= err_d;
    end
  end

  always_comb
  begin
    read_hit = dsm_known_reg(rd_addr); // see [R9]
  end

  // read mux; absent registers read zero
  always_comb
  begin
    read_word = dsm_pkg::DATA_RESET_VAL;
    unique case (rd_addr)
      dsm_pkg::ADDR_DRIVE_STATUS:
      begin
        read_word = status_word;
      end
      dsm_pkg::ADDR_RELAY_STATUS:
      begin
        read_word = relay_word;
      end
      dsm_pkg::ADDR_DC_BUS_VOLTAGE:
      begin
        read_word = dc_bus_voltage;
      end
      dsm_pkg::ADDR_TORQUE_READOUT:
      begin
        read_word = torque_monitor_item;
      end
      dsm_pkg::ADDR_POWER_READOUT:
      begin
        read_word = power_monitor_item;
      end
      dsm_pkg::ADDR_CPU_SW_NUMBER:
      begin
        read_word = cpu_software_number;
      end
      dsm_pkg::ADDR_FLASH_SW_NUMBER:
      begin
        read_word = flash_software_number;
      end
      dsm_pkg::ADDR_LINK_ERROR:
      begin
        read_word = {9'h000, err_q}; // see [R10]
      end
      dsm_pkg::ADDR_CAPACITY:
      begin
        read_word = drive_capacity_setting;
      end
      dsm_pkg::ADDR_CONTROL_METHOD:
      begin
        read_word = control_method_code;
      end
      default:
      begin
        read_word = dsm_pkg::DATA_RESET_VAL; // see [R10]
      end
    endcase
  end

  // answer strobe, one cycle after each taken read
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rd_valid <= 1'b0;
    end
    else if (clock_en)
    begin
      rd_valid <= rd_req;
    end
  end

  // read data held until the next taken read
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rd_data <= dsm_pkg::DATA_RESET_VAL;
    end
    else if (clock_en && rd_req)
    begin
      rd_data <= read_word; // see [R10]
    end
  end

  // exception code held with the read data
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      rd_exception <= dsm_pkg::EXC_NONE;
    end
    else if (clock_en && rd_req)
    begin
      rd_exception <= dsm_exc_code(read_hit); // see [R9]
    end
  end

endmodule

// File: dsm_pkg.sv
// Purpose: constants for the drive status monitor register bank
// Assumes: 16-bit registers addressed by register number
// Notes: register numbers as printed, word addressed
package dsm_pkg;
  localparam logic [15:0] ADDR_DRIVE_STATUS    = 16'h002c;
  localparam logic [15:0] ADDR_RELAY_STATUS    = 16'h002d;
  localparam logic [15:0] ADDR_DC_BUS_VOLTAGE  = 16'h0031;
  localparam logic [15:0] ADDR_TORQUE_READOUT  = 16'h0032;
  localparam logic [15:0] ADDR_POWER_READOUT   = 16'h0033;
  localparam logic [15:0] ADDR_CPU_SW_NUMBER   = 16'h003b;
  localparam logic [15:0] ADDR_FLASH_SW_NUMBER = 16'h003c;
  localparam logic [15:0] ADDR_LINK_ERROR      = 16'h003d;
  localparam logic [15:0] ADDR_CAPACITY        = 16'h003e;
  localparam logic [15:0] ADDR_CONTROL_METHOD  = 16'h003f;

  localparam int ST_RUNNING      = 0;
  localparam int ST_ZERO_SPEED   = 1;
  localparam int ST_FREQ_AGREE   = 2;
  localparam int ST_USER_AGREE   = 3;
  localparam int ST_FREQ_AT_BELOW = 4;
  localparam int ST_FREQ_AT_ABOVE = 5;
  localparam int ST_STARTUP_DONE = 6;
  localparam int ST_UNDERVOLT    = 7;
  localparam int ST_GATE_BLOCKED = 8;
  localparam int ST_FREF_NOT_COM = 9;
  localparam int ST_RUN_NOT_COM  = 10;
  localparam int ST_OVERTORQUE   = 11;
  localparam int ST_FREF_LOST    = 12;
  localparam int ST_RESTARTING   = 13;
  localparam int ST_ANY_ERROR    = 14;
  localparam int ST_LINK_TIMEOUT = 15;

  localparam int ERR_CRC     = 0;
  localparam int ERR_LENGTH  = 1;
  localparam int ERR_PARITY  = 3;
  localparam int ERR_OVERRUN = 4;
  localparam int ERR_FRAMING = 5;
  localparam int ERR_TIMEOUT = 6;

  localparam logic [6:0]  ERR_USED_MASK  = 7'h7b;
  localparam logic [6:0]  ERR_RESET_VAL  = 7'h00;
  localparam logic [15:0] DATA_RESET_VAL = 16'h0000;
  localparam logic [7:0]  EXC_BAD_REGISTER = 8'h02;
  localparam logic [7:0]  EXC_NONE         = 8'h00;
endpackage

// File: dsm_regs_assertions.sv
// Purpose: port checks for dsm_regs
// Assumes: one clock, sync reset
// Notes: bound to every dsm_regs
`timescale 1ns/1ps
module dsm_chk
(
  input wire logic        clock, reset, clock_en, drive_error, link_timeout, fref_from_comms,
  input wire logic        run_from_comms, relay_out1_pins, relay_out2_pins, relay_out3_pins,
  input wire logic        rx_crc_error, rx_length_error, rx_parity_error, rx_overrun_error,
  input wire logic        rx_framing_error, rx_timeout_error, error_reset, rd_req, rd_valid,
  input wire logic [15:0] output_freq, freq_detect_level, rd_addr, rd_data,
  input wire logic [7:0]  rd_exception
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire any_rx = rx_crc_error | rx_length_error | rx_parity_error | rx_overrun_error
    | rx_framing_error | rx_timeout_error;
  sequence s_rd(logic [15:0] a); clock_en && rd_req && rd_addr == a; endsequence
  a_read_answered: assert property (clock_en && rd_req |=> rd_valid)
    else $error("read not answered");
  a_valid_single: assert property (clock_en && !rd_req |=> !rd_valid)
    else $error("answer without read");
  a_freq_compare: assert property (s_rd(16'h002c) |=> rd_data[5:4] == {$past(output_freq) >=
    $past(freq_detect_level), $past(output_freq) <= $past(freq_detect_level)}) else $error("bits 5:4");
  a_error_flags: assert property (s_rd(16'h002c) |=> rd_data[15:14] ==
    {$past(link_timeout), $past(drive_error | link_timeout)}) else $error("bits 15:14");
  a_source_inverted: assert property (s_rd(16'h002c) |=> rd_data[10:9] ==
    ~$past({run_from_comms, fref_from_comms})) else $error("bits 10:9");
  a_relay_bits: assert property (s_rd(16'h002d) |=> rd_data == {13'h0000,
    $past({relay_out3_pins, relay_out2_pins, relay_out1_pins})}) else $error("relay word");
  a_unknown_reg: assert property (clock_en && rd_req && !(rd_addr inside {16'h002c, 16'h002d,
    [16'h0031:16'h0033], [16'h003b:16'h003f]}) |=> rd_exception == 8'h02 && rd_data == 16'h0000)
    else $error("unknown register answered");
  a_error_sticky: assert property (clock_en && rx_parity_error ##1 s_rd(16'h003d) |=> rd_data[3])
    else $error("parity bit lost");
  a_error_cleared: assert property (clock_en && error_reset && !any_rx ##1 s_rd(16'h003d)
    |=> rd_data == 16'h0000) else $error("error word not cleared");
  c_status_read: cover property (s_rd(16'h002c) ##1 rd_valid);
  c_error_read: cover property (s_rd(16'h003d) ##1 rd_data != 16'h0000);
  c_reset_event: cover property (error_reset && rx_parity_error);
endmodule
bind dsm_regs dsm_chk u_chk (.*);

// File: dsm_master.sv
// Purpose: remote master issuing register reads
// Assumes: one strobe per read, answer one cycle later
// Notes: address shows its inverse once released
`timescale 1ns/1ps
module dsm_master
(
  input  wire logic        clock,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  input  wire logic [7:0]  rd_exception,
  output logic             rd_req,
  output logic [15:0]      rd_addr
);
  initial rd_req = 1'b0;
  initial rd_addr = 16'h0000;
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic [7:0] e,
    output logic ok);
    @(negedge clock);
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge clock);
    rd_req = 1'b0;
    rd_addr = ~a;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++)
      if (rd_valid === 1'b1) ok = 1'b1;
      else @(negedge clock);
    d = rd_data;
    e = rd_exception;
  endtask
endmodule

// File: tb_dsm_regs.sv
// Purpose: bench for dsm_regs
// Assumes: reads go through dsm_master
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_dsm_regs;
  logic clock = 1'b0, reset = 1'b1, clock_en = 1'b1, error_reset = 1'b0, ok, rd_req, rd_valid;
  logic [15:0] st = 16'ha5c3, output_freq = 16'h0000, freq_detect_level = 16'h0100, d;
  logic [15:0] rd_addr, rd_data;
  logic [7:0]  rd_exception, e;
  logic [2:0]  rel = 3'h0;
  logic [5:0]  rx = 6'h00, acc = 6'h00;
  logic [15:0] mon [7] = '{default: 16'h0000};
  logic [15:0] adr [7] = '{16'h0031, 16'h0032, 16'h0033, 16'h003b, 16'h003c, 16'h003e, 16'h003f};
  logic [15:0] bad [6] = '{16'h002b, 16'h002e, 16'h0030, 16'h0034, 16'h003a, 16'h0040};
  int bad_count = 0, total_checks = 0;
  wire drive_running = st[0], zero_speed = st[1], freq_agree = st[2], user_speed_agree = st[3];
  wire startup_done = st[6], undervoltage = st[7], gating_blocked = st[8], fref_from_comms = st[9];
  wire run_from_comms = st[10], overtorque = st[11], fref_lost = st[12], restarting = st[13];
  wire drive_error = st[14], link_timeout = st[15];
  wire relay_out1_pins = rel[0], relay_out2_pins = rel[1], relay_out3_pins = rel[2];
  wire rx_crc_error = rx[0], rx_length_error = rx[1], rx_parity_error = rx[2];
  wire rx_overrun_error = rx[3], rx_framing_error = rx[4], rx_timeout_error = rx[5];
  wire [15:0] dc_bus_voltage = mon[0], torque_monitor_item = mon[1], power_monitor_item = mon[2];
  wire [15:0] cpu_software_number = mon[3], flash_software_number = mon[4];
  wire [15:0] drive_capacity_setting = mon[5], control_method_code = mon[6];
  always #10 clock = ~clock;
  dsm_regs DUT (.*);
  dsm_master M (.*);
  function automatic logic [15:0] exp_st();
    return (st & 16'hb9cf) | {1'b0, st[15] | st[14], 3'h0, ~st[10:9], 3'h0,
      output_freq >= freq_detect_level, output_freq <= freq_detect_level, 4'h0};
  endfunction
  task test_done();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] xd, input logic [7:0] xe);
    M.rd(a, d, e, ok);
    `CHK(ok, 1'b1)
    if (ok !== 1'b1) test_done();
    `CHK(d, xd)
    `CHK(e, xe)
  endtask
  initial
  begin
    repeat (8) @(negedge clock);
    reset = 1'b0;
    `CHK({rd_valid, rd_data, rd_exception}, 25'h0)
    for (int i = 0; i < 3; i++)
    begin
      output_freq = 16'h00ff + 16'(i);
      st = st ^ 16'hffff;
      rd(16'h002c, exp_st(), 8'h00);
    end
    for (int i = 2; i < 6; i += 3)
    begin
      rel = 3'(i);
      rd(16'h002d, {13'h0000, rel}, 8'h00);
    end
    foreach (mon[i]) mon[i] = 16'(16'h1111 * (i + 1));
    foreach (adr[i]) rd(adr[i], mon[i], 8'h00);
    foreach (bad[i]) rd(bad[i], 16'h0000, 8'h02);
    for (int i = 0; i < 6; i++)
    begin
      rx[i] = 1'b1;
      acc[i] = 1'b1;
      @(negedge clock) rx = 6'h00;
      rd(16'h003d, {9'h000, acc[5:2], 1'b0, acc[1:0]}, 8'h00);
    end
    rx[2] = 1'b1;
    error_reset = 1'b1;
    @(negedge clock) {rx, error_reset} = 7'h00;
    rd(16'h003d, 16'h0008, 8'h00);
    error_reset = 1'b1;
    @(negedge clock) error_reset = 1'b0;
    rd(16'h003d, 16'h0000, 8'h00);
    clock_en = 1'b0;
    rx = 6'h01;
    repeat (2) @(negedge clock);
    `CHK({rd_valid, rd_data}, {1'b1, 16'h0000})
    {clock_en, rx} = 7'h40;
    rd(16'h003d, 16'h0000, 8'h00);
    test_done();
  end
endmodule
